// >>> svtmc_cfg.svh
// Register indices, field positions, reset values and mode geometry of the video timing block
`ifndef SVTMC_CFG_SVH
`define SVTMC_CFG_SVH

`define SVTMC_REG_MODE       8'h10
`define SVTMC_REG_FMT        8'h11
`define SVTMC_REG_QCK        8'h14
`define SVTMC_REG_CLKCFG     8'h16
`define SVTMC_REG_COPROC     8'h18
`define SVTMC_REG_LINE_HI    8'h60
`define SVTMC_REG_LINE_LO    8'h61
`define SVTMC_REG_FIELD_HI   8'h62
`define SVTMC_REG_FIELD_LO   8'h63
`define SVTMC_REG_CLKDIV     8'h64
`define SVTMC_REG_BLACK      8'h65

`define SVTMC_RATE_BIT       3
`define SVTMC_BLKBUS_BIT     5
`define SVTMC_SHUF_BIT       7
`define SVTMC_PREDIV_BIT     7
`define SVTMC_COPROC_BIT     0
`define SVTMC_QCK_FREE_BIT   2
`define SVTMC_QCK_FAST_BIT   3

`define SVTMC_MODE_RST       8'h02
`define SVTMC_FMT_RST        8'h80
`define SVTMC_QCK_RST        8'h00
`define SVTMC_QCK_FREE_VAL   8'h04
`define SVTMC_CLKCFG_RST     8'h00
`define SVTMC_COPROC_RST     8'h01
`define SVTMC_CLKDIV_RST     8'h40

`define SVTMC_LL_PAL         10'h1C5
`define SVTMC_LL_NTSC        10'h16B
`define SVTMC_LL_CIF25       10'h1F3
`define SVTMC_LL_CIF30       10'h19F
`define SVTMC_LL_Q25         10'h0F9
`define SVTMC_LL_Q30         10'h0CF
`define SVTMC_FL_PAL         10'h137
`define SVTMC_FL_NTSC        10'h105
`define SVTMC_FL_CIF         10'h13F
`define SVTMC_FL_Q           10'h09F
`define SVTMC_DIV_TV         4'h2
`define SVTMC_DIV_CIF        4'h4
`define SVTMC_DIV_Q          4'h8

`define SVTMC_ARRAY_W        9'h16C
`define SVTMC_ARRAY_H        9'h128
`define SVTMC_W_NTSC         9'h132
`define SVTMC_H_NTSC         9'h0F4
`define SVTMC_W_FULL         9'h164
`define SVTMC_H_FULL         9'h124
`define SVTMC_W_Q            9'h0B4
`define SVTMC_H_Q            9'h094
`define SVTMC_X_FULL         9'h004
`define SVTMC_Y_FULL         9'h002
`define SVTMC_X_NTSC         9'h01C
`define SVTMC_Y_NTSC         9'h01A
`define SVTMC_X_Q            9'h05C
`define SVTMC_Y_Q            9'h04A

`endif

// >>> svtmc_pkg.sv
// Types shared by the video timing and mode control block
package svtmc_pkg;
	typedef enum logic [2:0] {
		SVTMC_PAL   = 3'h0,
		SVTMC_NTSC  = 3'h1,
		SVTMC_CIF   = 3'h2,
		SVTMC_CROPQ = 3'h3,
		SVTMC_SUBQ  = 3'h4
	} svtmc_mode_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} svtmc_wr_t;

	typedef struct packed {
		logic [9:0] lineLen;
		logic [9:0] fieldLen;
		logic [3:0] sysDiv;
		logic       tvTiming;
	} svtmc_arb_t;

	typedef struct packed {
		logic [8:0] w;
		logic [8:0] h;
		logic [8:0] x;
		logic [8:0] y;
	} svtmc_geom_t;
endpackage

// >>> svtmc_timing.sv
// Video mode registers, mode arbitration, clock division and raster timing generator
`timescale 1ns/1ps
`default_nettype none
`include "svtmc_cfg.svh"

module svtmc_timing (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire logic                    lowPower,
	input  wire svtmc_pkg::svtmc_wr_t    regWr,
	output var  svtmc_pkg::svtmc_mode_t  modeCode,
	output logic                         slowRate,
	output logic [9:0]                   lineLen,
	output logic [9:0]                   fieldLen,
	output logic [7:0]                   clkDiv,
	output logic                         qckFreeRun,
	output logic                         qckFast,
	output logic                         extraBlackEn,
	output logic                         blackOnBus,
	output logic                         shuffleEn,
	output logic                         preDiv15,
	output logic                         pixTick,
	output logic                         lineStart,
	output logic                         frameStart,
	output logic                         oddField,
	output logic                         pixValid,
	output logic [8:0]                   pixAddrX,
	output logic [8:0]                   pixAddrY
);
	// ------------------------------------------------------------
	// Mode tables
	// ------------------------------------------------------------
	function automatic svtmc_pkg::svtmc_mode_t decodeMode(input logic [2:0] code);
		case (code)
			3'h0:    decodeMode = svtmc_pkg::SVTMC_PAL;
			3'h1:    decodeMode = svtmc_pkg::SVTMC_NTSC;
			3'h3:    decodeMode = svtmc_pkg::SVTMC_CROPQ;
			3'h4:    decodeMode = svtmc_pkg::SVTMC_SUBQ;
			default: decodeMode = svtmc_pkg::SVTMC_CIF;
		endcase
	endfunction

	function automatic svtmc_pkg::svtmc_arb_t arbValues(input svtmc_pkg::svtmc_mode_t m, input logic slow);
		svtmc_pkg::svtmc_arb_t a;
		a = '0;
		case (m)
			svtmc_pkg::SVTMC_PAL:  a = '{`SVTMC_LL_PAL, `SVTMC_FL_PAL, `SVTMC_DIV_TV, 1'b1};
			svtmc_pkg::SVTMC_NTSC: a = '{`SVTMC_LL_NTSC, `SVTMC_FL_NTSC, `SVTMC_DIV_TV, 1'b1};
			svtmc_pkg::SVTMC_CIF:  a = '{slow ? `SVTMC_LL_CIF25 : `SVTMC_LL_CIF30,
				`SVTMC_FL_CIF, `SVTMC_DIV_CIF, 1'b0};
			default: a = '{slow ? `SVTMC_LL_Q25 : `SVTMC_LL_Q30, `SVTMC_FL_Q, `SVTMC_DIV_Q, 1'b0};
		endcase
		return a;
	endfunction

	function automatic svtmc_pkg::svtmc_geom_t geomOf(input svtmc_pkg::svtmc_mode_t m);
		svtmc_pkg::svtmc_geom_t g;
		g = '0;
		case (m)
			// NTSC sits off-centre so its corner stays a green-one pixel
			svtmc_pkg::SVTMC_NTSC:  g = '{`SVTMC_W_NTSC, `SVTMC_H_NTSC, `SVTMC_X_NTSC, `SVTMC_Y_NTSC};
			svtmc_pkg::SVTMC_CROPQ: g = '{`SVTMC_W_Q, `SVTMC_H_Q, `SVTMC_X_Q, `SVTMC_Y_Q};
			svtmc_pkg::SVTMC_SUBQ:  g = '{`SVTMC_W_Q, `SVTMC_H_Q, `SVTMC_X_FULL, `SVTMC_Y_FULL};
			default: g = '{`SVTMC_W_FULL, `SVTMC_H_FULL, `SVTMC_X_FULL, `SVTMC_Y_FULL};
		endcase
		return g;
	endfunction

	// Odd pixels (even indices) first when shuffled; subsampling keeps pairs, skips pairs
	function automatic logic [8:0] mapIdx(input logic [8:0] idx, input logic [8:0] size,
		input logic shuf, input logic sub);
		logic [8:0] half;
		logic [8:0] s;
		half = size >> 1;
		if (shuf && idx >= half) begin
			s = 9'(((idx - half) << 1) | 9'h001);
		end else if (shuf) begin
			s = 9'(idx << 1);
		end else begin
			s = idx;
		end
		return sub ? {s[7:1], 1'b0, s[0]} : s;
	endfunction

	// ------------------------------------------------------------
	// Register writes and arbitration
	// ------------------------------------------------------------
	logic [7:0] regFmt;
	logic [7:0] regQck;
	logic [7:0] regClkCfg;
	logic [7:0] regCoproc;
	logic       regBlack;

	wire wMode    = regWr.en && regWr.addr == `SVTMC_REG_MODE;
	wire wFmt     = regWr.en && regWr.addr == `SVTMC_REG_FMT;
	wire wQck     = regWr.en && regWr.addr == `SVTMC_REG_QCK;
	wire wClkCfg  = regWr.en && regWr.addr == `SVTMC_REG_CLKCFG;
	wire wCoproc  = regWr.en && regWr.addr == `SVTMC_REG_COPROC;
	wire wLineHi  = regWr.en && regWr.addr == `SVTMC_REG_LINE_HI;
	wire wLineLo  = regWr.en && regWr.addr == `SVTMC_REG_LINE_LO;
	wire wFieldHi = regWr.en && regWr.addr == `SVTMC_REG_FIELD_HI;
	wire wFieldLo = regWr.en && regWr.addr == `SVTMC_REG_FIELD_LO;
	wire wClkDiv  = regWr.en && regWr.addr == `SVTMC_REG_CLKDIV;
	wire wBlack   = regWr.en && regWr.addr == `SVTMC_REG_BLACK;

	wire svtmc_pkg::svtmc_mode_t newMode = decodeMode(regWr.data[2:0]);
	wire svtmc_pkg::svtmc_arb_t  newArb  = arbValues(newMode, regWr.data[`SVTMC_RATE_BIT]);

	// A mode write forces every dependent value regardless of what it held
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modeCode  <= svtmc_pkg::SVTMC_CIF;
			slowRate  <= 1'b0;
			lineLen   <= `SVTMC_LL_CIF30;
			fieldLen  <= `SVTMC_FL_CIF;
			clkDiv    <= `SVTMC_CLKDIV_RST;
			regQck    <= `SVTMC_QCK_RST;
			regBlack  <= 1'b0;
		end else if (ce && wMode) begin
			modeCode  <= newMode;
			slowRate  <= regWr.data[`SVTMC_RATE_BIT];
			lineLen   <= newArb.lineLen;
			fieldLen  <= newArb.fieldLen;
			clkDiv    <= {newArb.sysDiv, clkDiv[3:0]};
			regQck    <= newArb.tvTiming ? `SVTMC_QCK_FREE_VAL : `SVTMC_QCK_RST;
			regBlack  <= newArb.tvTiming;
		end else if (ce) begin
			if (wLineHi)  lineLen[9:8]  <= regWr.data[1:0];
			if (wLineLo)  lineLen[7:0]  <= regWr.data;
			if (wFieldHi) fieldLen[9:8] <= regWr.data[1:0];
			if (wFieldLo) fieldLen[7:0] <= regWr.data;
			if (wClkDiv)  clkDiv[3:0]   <= regWr.data[3:0];
			if (wQck)     regQck        <= regWr.data;
			if (wBlack)   regBlack      <= regWr.data[0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regFmt    <= `SVTMC_FMT_RST;
			regClkCfg <= `SVTMC_CLKCFG_RST;
			regCoproc <= `SVTMC_COPROC_RST;
		end else if (ce) begin
			if (wFmt)    regFmt    <= regWr.data;
			if (wClkCfg) regClkCfg <= regWr.data;
			if (wCoproc) regCoproc <= regWr.data;
		end
	end

	// Outputs are registered, so decoded flags lag their source register by one cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			qckFreeRun   <= 1'b0;
			qckFast      <= 1'b0;
			extraBlackEn <= 1'b0;
			blackOnBus   <= 1'b0;
			shuffleEn    <= 1'b1;
			preDiv15     <= 1'b0;
		end else if (ce) begin
			qckFreeRun   <= regQck[`SVTMC_QCK_FREE_BIT];
			qckFast      <= regQck[`SVTMC_QCK_FAST_BIT];
			extraBlackEn <= regBlack || !regCoproc[`SVTMC_COPROC_BIT];
			blackOnBus   <= regFmt[`SVTMC_BLKBUS_BIT];
			shuffleEn    <= regFmt[`SVTMC_SHUF_BIT];
			preDiv15     <= regClkCfg[`SVTMC_PREDIV_BIT];
		end
	end

	// ------------------------------------------------------------
	// Clock division
	// ------------------------------------------------------------
	logic [1:0] phase3;
	logic [6:0] divCnt;

	// Two enables in every three cycles gives the 1.5 ratio without a second clock
	wire        preTick = !preDiv15 || phase3 != 2'h2;
	wire [3:0]  pixDiv  = clkDiv[3:0] == 4'h0 ? 4'h1 : clkDiv[3:0];
	wire [6:0]  divLast = 7'(clkDiv[7:4] * pixDiv - 8'h01);
	wire        divWrap = preTick && divCnt >= divLast;
	wire        running = !lowPower;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase3 <= 2'h0;
			divCnt <= 7'h00;
			pixTick <= 1'b0;
		end else if (ce) begin
			phase3  <= (phase3 == 2'h2 || !preDiv15) ? 2'h0 : phase3 + 2'h1;
			divCnt  <= (divWrap || !running) ? 7'h00 : divCnt + 7'(preTick);
			pixTick <= divWrap && running;
		end
	end

	// ------------------------------------------------------------
	// Raster counters and readout addresses
	// ------------------------------------------------------------
	logic [9:0] col;
	logic [9:0] row;

	wire svtmc_pkg::svtmc_geom_t geom = geomOf(modeCode);
	wire        tvMode  = modeCode == svtmc_pkg::SVTMC_PAL || modeCode == svtmc_pkg::SVTMC_NTSC;
	wire        subMode = modeCode == svtmc_pkg::SVTMC_SUBQ;
	wire [9:0]  rowLast = fieldLen + 10'(tvMode && oddField);
	wire        colEnd  = col >= lineLen;
	wire        rowEnd  = row >= rowLast;
	wire        inWin   = col < 10'(geom.w) && row < 10'(geom.h);
	wire [8:0]  nextX   = geom.x + mapIdx(col[8:0], geom.w, shuffleEn, subMode);
	wire [8:0]  nextY   = geom.y + mapIdx(row[8:0], geom.h, 1'b0, subMode);

	// Counters restart while in low power so the first frame after exit is whole
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			col <= 10'h000;
			row <= 10'h000;
			oddField <= 1'b0;
		end else if (ce && !running) begin
			col <= 10'h000;
			row <= 10'h000;
			oddField <= 1'b0;
		end else if (ce && pixTick) begin
			col <= colEnd ? 10'h000 : col + 10'h001;
			if (colEnd) row <= rowEnd ? 10'h000 : row + 10'h001;
			if (colEnd && rowEnd) oddField <= !oddField;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lineStart  <= 1'b0;
			frameStart <= 1'b0;
			pixValid   <= 1'b0;
			pixAddrX   <= 9'h000;
			pixAddrY   <= 9'h000;
		end else if (ce) begin
			lineStart  <= pixTick && running && col == 10'h000;
			frameStart <= pixTick && running && col == 10'h000 && row == 10'h000;
			pixValid   <= pixTick && running && inWin;
			pixAddrX   <= nextX;
			pixAddrY   <= nextY;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_cif30_line_len: assert property (ce && wMode && regWr.data[2:0] == 3'h2 && !regWr.data[3]
		|=> lineLen == `SVTMC_LL_CIF30 && fieldLen == `SVTMC_FL_CIF)
		else $error("common format 30 fps lengths not forced");
	a_pal_sys_div: assert property (ce && wMode && regWr.data[2:0] == 3'h0
		|=> clkDiv[7:4] == `SVTMC_DIV_TV && lineLen == `SVTMC_LL_PAL && regQck == `SVTMC_QCK_FREE_VAL)
		else $error("PAL arbitration values wrong");
	a_rate_bit_mode: assert property (ce && wMode |=> slowRate == $past(regWr.data[3]))
		else $error("rate bit not taken from mode write");
	a_override_line: assert property (ce && wLineLo && !wMode |=> lineLen[7:0] == $past(regWr.data))
		else $error("line length write did not override");
	a_host_nibble: assert property (ce && wClkDiv |=> clkDiv[7:4] == $past(clkDiv[7:4]))
		else $error("host write changed mode nibble");
	a_qck_free_slow: assert property (ce && wQck && regWr.data == `SVTMC_QCK_FREE_VAL
		##1 ce |=> qckFreeRun && !qckFast)
		else $error("free-running slow qualification clock not enabled");
	a_black_coproc: assert property (ce && !regCoproc[0] |=> extraBlackEn)
		else $error("extra black lines not forced on");
	a_pix_tick_gap: assert property (ce && pixTick |=> !pixTick)
		else $error("pixel tick faster than system divide");
	a_addr_in_array: assert property (pixValid |-> pixAddrX < `SVTMC_ARRAY_W && pixAddrY < `SVTMC_ARRAY_H)
		else $error("readout address outside array");
	a_low_power_idle: assert property (lowPower && ce ##1 ce |=> !pixTick && !frameStart)
		else $error("timing ran in low power");

	c_pal_selected: cover property (ce && wMode && regWr.data[2:0] == 3'h0);
	c_frame_start: cover property (frameStart);
	c_shuffled_pixel: cover property (pixValid && shuffleEn);
	c_prediv_tick: cover property (pixTick && preDiv15);
endmodule

`default_nettype wire

// >>> svtmc_host_model.sv
// Far-side model: co-processor clock enable and host register writes
`timescale 1ns/1ps
`default_nettype none
module svtmc_host_model (
	input  wire logic                 core_clk,
	output var  logic                 ce,
	output var  svtmc_pkg::svtmc_wr_t regWr
);
	// ----------------------------------------
	// Clock enable and write port
	// ----------------------------------------
	initial begin
		ce = 1'b1;
		regWr = '{1'b0, 8'h00, 8'h00};
	end

	// Gating ce stands in for a slower or stopped input clock
	task automatic setCe(input logic on);
		@(posedge core_clk);
		#1 ce = on;
	endtask

	// Strobe lasts one edge; afterwards address and data are scrambled, not held
	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		#1 regWr = '{1'b1, addr, data};
		@(posedge core_clk);
		#1 regWr = '{1'b0, ~addr, ~data};
	endtask
endmodule
`default_nettype wire

// >>> svtmc_timing_bench.sv
// Self-checking testbench of the video timing and mode control block
`timescale 1ns/1ps
`default_nettype none
module svtmc_timing_bench;
	logic                   core_clk;
	logic                   rst;
	logic                   lowPower;
	logic                   ce;
	svtmc_pkg::svtmc_wr_t   regWr;
	svtmc_pkg::svtmc_mode_t modeCode;
	logic                   slowRate;
	logic [9:0]             lineLen;
	logic [9:0]             fieldLen;
	logic [7:0]             clkDiv;
	logic                   qckFreeRun;
	logic                   qckFast;
	logic                   extraBlackEn;
	logic                   blackOnBus;
	logic                   shuffleEn;
	logic                   preDiv15;
	logic                   pixTick;
	logic                   lineStart;
	logic                   frameStart;
	logic                   oddField;
	logic                   pixValid;
	logic [8:0]             pixAddrX;
	logic [8:0]             pixAddrY;
	int                     errors;
	int                     checked;

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	svtmc_host_model u_host (.core_clk(core_clk), .ce(ce), .regWr(regWr));

	svtmc_timing u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .lowPower(lowPower), .regWr(regWr),
		.modeCode(modeCode), .slowRate(slowRate), .lineLen(lineLen), .fieldLen(fieldLen), .clkDiv(clkDiv),
		.qckFreeRun(qckFreeRun), .qckFast(qckFast), .extraBlackEn(extraBlackEn), .blackOnBus(blackOnBus),
		.shuffleEn(shuffleEn), .preDiv15(preDiv15), .pixTick(pixTick), .lineStart(lineStart),
		.frameStart(frameStart), .oddField(oddField), .pixValid(pixValid), .pixAddrX(pixAddrX),
		.pixAddrY(pixAddrY));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic doReset();
		@(posedge core_clk);
		#1 rst = 1'b1;
		cyc(4);
		rst = 1'b0;
	endtask

	// Extra cycle lets the decoded flags catch up with the register
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.write(a, d);
		cyc(1);
	endtask

	// Bounded wait for a pulse; n returns cycles waited
	task automatic waitPulse(input int sel, output int n);
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit && n < 5000) begin
			cyc(1);
			n++;
			case (sel)
				0: hit = (pixTick === 1'b1);
				1: hit = (lineStart === 1'b1);
				2: hit = (pixValid === 1'b1);
				default: hit = (frameStart === 1'b1);
			endcase
		end
		if (!hit)
			check("pulse present", 32'h0, 32'h1);
	endtask

	task automatic gap(input string name, input int sel, input int exp);
		int n;
		waitPulse(sel, n);
		waitPulse(sel, n);
		check(name, n, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tReset();
		doReset();
		check("modeCode", modeCode, 32'h2);
		check("lineLen", lineLen, 32'h19F);
		check("fieldLen", fieldLen, 32'h13F);
		check("clkDiv", clkDiv, 32'h40);
		check("shuffleEn", shuffleEn, 32'h1);
		check("slowRate", slowRate, 32'h0);
		$display("test reset done");
	endtask

	task automatic tModes();
		logic [9:0] el;
		logic [9:0] ef;
		logic [3:0] ed;
		for (int c = 0; c < 8; c++) begin
			for (int s = 0; s < 2; s++) begin
				wr(8'h10, {4'h0, s[0], c[2:0]});
				case (c)
					0: begin el = 10'h1C5; ef = 10'h137; ed = 4'h2; end
					1: begin el = 10'h16B; ef = 10'h105; ed = 4'h2; end
					2, 5, 6, 7: begin el = s ? 10'h1F3 : 10'h19F; ef = 10'h13F; ed = 4'h4; end
					default: begin el = s ? 10'h0F9 : 10'h0CF; ef = 10'h09F; ed = 4'h8; end
				endcase
				check("modeCode", modeCode, (c > 4) ? 2 : c);
				check("slowRate", slowRate, s);
				check("lineLen", lineLen, el);
				check("fieldLen", fieldLen, ef);
				check("sysDiv", clkDiv[7:4], ed);
				check("qckFreeRun", qckFreeRun, c < 2);
				check("extraBlackEn", extraBlackEn, c < 2);
			end
		end
		$display("test modes done");
	endtask

	task automatic tOverride();
		wr(8'h10, 8'h00);
		wr(8'h61, 8'h23);
		wr(8'h60, 8'h01);
		check("lineLen", lineLen, 32'h123);
		wr(8'h64, 8'hF3);
		check("clkDiv", clkDiv, 32'h23);
		wr(8'h65, 8'h00);
		check("extraBlackEn", extraBlackEn, 32'h0);
		wr(8'h10, 8'h00);
		check("lineLen", lineLen, 32'h1C5);
		check("sysDiv", clkDiv[7:4], 32'h2);
		check("extraBlackEn", extraBlackEn, 32'h1);
		wr(8'h33, 8'hFF);
		u_host.setCe(1'b0);
		wr(8'h61, 8'h00);
		u_host.setCe(1'b1);
		cyc(1);
		check("lineLen", lineLen, 32'h1C5);
		$display("test override done");
	endtask

	task automatic tFlags();
		doReset();
		wr(8'h14, 8'h04);
		check("qckFreeRun", qckFreeRun, 32'h1);
		check("qckFast", qckFast, 32'h0);
		wr(8'h11, 8'hA0);
		check("blackOnBus", blackOnBus, 32'h1);
		// Monochrome host drops the shuffle
		wr(8'h11, 8'h20);
		check("shuffleEn", shuffleEn, 32'h0);
		wr(8'h18, 8'h00);
		check("extraBlackEn", extraBlackEn, 32'h1);
		wr(8'h16, 8'h80);
		check("preDiv15", preDiv15, 32'h1);
		$display("test flags done");
	endtask

	task automatic tTiming();
		int n;
		doReset();
		gap("pixel period", 0, 4);
		gap("line period", 1, 1664);
		wr(8'h10, 8'h0A);
		gap("line period", 1, 2000);
		wr(8'h64, 8'h02);
		gap("pixel period", 0, 8);
		wr(8'h64, 8'h00);
		wr(8'h16, 8'h80);
		gap("pixel period", 0, 6);
		doReset();
		lowPower = 1'b1;
		wr(8'h61, 8'h09);
		wr(8'h60, 8'h00);
		wr(8'h63, 8'h02);
		wr(8'h62, 8'h00);
		lowPower = 1'b0;
		gap("frame period", 3, 120);
		check("oddField", oddField, 32'h1);
		// Short PAL fields: even field 3 lines, odd field one line more
		lowPower = 1'b1;
		wr(8'h10, 8'h00);
		wr(8'h61, 8'h09);
		wr(8'h60, 8'h00);
		wr(8'h63, 8'h02);
		wr(8'h62, 8'h00);
		lowPower = 1'b0;
		gap("even field period", 3, 60);
		waitPulse(3, n);
		check("odd field period", n, 80);
		$display("test timing done");
	endtask

	task automatic tWindow();
		int n;
		logic [7:0] codes [5];
		logic [8:0] ex [5];
		logic [8:0] ey [5];
		logic [8:0] ex2 [5];
		codes = '{8'h01, 8'h03, 8'h02, 8'h04, 8'h02};
		ex = '{9'h01C, 9'h05C, 9'h004, 9'h004, 9'h004};
		ey = '{9'h01A, 9'h04A, 9'h002, 9'h002, 9'h002};
		// Subsampled quarter: shuffled column 1 maps to index 2, which the pair skip moves to 4
		ex2 = '{9'h01E, 9'h05E, 9'h006, 9'h008, 9'h005};
		doReset();
		for (int i = 0; i < 5; i++) begin
			lowPower = 1'b1;
			cyc(20);
			check("pixTick", pixTick, 32'h0);
			wr(8'h10, codes[i]);
			wr(8'h65, 8'h00);
			if (i == 4)
				wr(8'h11, 8'h00);
			lowPower = 1'b0;
			waitPulse(2, n);
			check("pixAddrX", pixAddrX, ex[i]);
			check("pixAddrY", pixAddrY, ey[i]);
			waitPulse(2, n);
			check("pixAddrX next", pixAddrX, ex2[i]);
		end
		$display("test window done");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		errors = 0;
		checked = 0;
		rst = 1'b1;
		lowPower = 1'b0;
		tReset();
		tModes();
		tOverride();
		tFlags();
		tTiming();
		tWindow();
		complete_run();
	end

	// Whole run needs under 10k cycles; 80k means a hang
	initial begin
		#800000;
		errors++;
		complete_run();
	end
endmodule
`default_nettype wire
